// ===== design/wese_pkg.sv
// shared constants for the wake event status and enable block
package wese_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS_GRP5 = 6'h08;
  localparam logic [5:0] IDX_RESERVED_ZERO = 6'h09;
  localparam logic [5:0] IDX_EN_MISC = 6'h0a;
  localparam logic [5:0] IDX_EN_GRP1 = 6'h0b;
  localparam logic [5:0] IDX_EN_GRP2 = 6'h0c;
  localparam logic [5:0] IDX_WAKE_CTRL = 6'h10;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h12;

  // reset values, applied only by the standby-power reset
  localparam logic [7:0] WAKE_STATUS_RESET = 8'h00;
  localparam logic [7:0] WAKE_ENABLE_RESET = 8'h00;
  localparam logic [7:0] WAKE_CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // bit positions of the miscellaneous enable register
  localparam int CONSUMER_INFRARED_POS = 0;
  localparam int RING_TWO_POS = 1;
  localparam int RING_ONE_POS = 2;
  localparam int KEYBOARD_POS = 3;
  localparam int MOUSE_POS = 4;
  localparam int SPECIFIC_KEY_POS = 5;
  localparam int FAN_ONE_POS = 6;
  localparam int FAN_TWO_POS = 7;

  // group-2 enable bit that stands for the grouped interrupt
  localparam int GROUPED_INT_POS = 3;

  // control and interrupt field positions
  localparam int GLOBAL_ENABLE_POS = 0;
  localparam int IRQ_GRP5_EVENT_POS = 0;
  localparam int IRQ_WAKE_ASSERT_POS = 1;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== design/wese_flag_if.sv
// sticky flag bank connection between owner logic and a flag bank
interface wese_flag_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] w1c;
  logic rd_clr;
  logic [W-1:0] flags;
  modport bank (input set, input w1c, input rd_clr, output flags);
  modport owner (output set, output w1c, output rd_clr, input flags);
endinterface

// ===== design/wese_sticky.sv
// bank of sticky flags with write-one clear and read clear
module wese_sticky
  import wese_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VALUE = '0
)
(
  input wire logic aclk,
  input wire logic aresetn,
  wese_flag_if.bank f
);
  typedef struct packed
  {
    logic [W-1:0] flags;
  } wese_sticky_state_t;

  wese_sticky_state_t s;
  wese_sticky_state_t next_s;

  // a set in the same cycle as a clear wins so no event is lost
  always_comb
  begin
    next_s = s;
    next_s.flags = (s.flags & ~f.w1c & ~{W{f.rd_clr}}) | f.set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s.flags <= RESET_VALUE;
    else
      s <= next_s;
  end

  assign f.flags = s.flags;
endmodule

// ===== design/wese_gate.sv
// per-source status and enable products folded onto the wake request
module wese_gate
  import wese_pkg::*;
#(
  parameter int N = 24
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] status,
  input wire logic [N-1:0] enable,
  input wire logic global_enable,
  output logic wake_request_n
);
  typedef struct packed
  {
    logic req_n;
  } wese_gate_state_t;

  wese_gate_state_t s;
  wese_gate_state_t next_s;
  logic [N-1:0] hit;

  // a source counts only with its status and its enable both set
  for (genvar i = 0; i < N; i++)
  begin : g_src
    assign hit[i] = status[i] & enable[i];
  end

  // active low, gated as a whole by the global enable
  always_comb
  begin
    next_s = s;
    next_s.req_n = !(global_enable && (|hit));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s.req_n <= 1'b1;
    else
      s <= next_s;
  end

  assign wake_request_n = s.req_n;
endmodule

// ===== design/wese_top.sv
// wake event status and enable registers behind an axi4-lite slave
//
// The AXI4-Lite slave port was decided locally.
module wese_top
  import wese_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pin_group5_wake,
  input wire logic consumer_infrared_wake,
  input wire logic ring_indicator_one,
  input wire logic ring_indicator_two,
  input wire logic keyboard_wake,
  input wire logic mouse_wake,
  input wire logic specific_key_wake,
  input wire logic fan_speed_input_one,
  input wire logic fan_speed_input_two,
  input wire logic [7:0] pin_group1_wake_status,
  input wire logic [7:0] pin_group2_wake_status,
  input wire logic grouped_interrupt_wake,
  output logic wake_request_n,
  output logic irq
);
  typedef struct packed
  {
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rd_pend;
    logic [ADDR_W-1:0] raddr;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] wake_enable_misc_sources;
    logic [7:0] wake_enable_pin_group1;
    logic [7:0] wake_enable_pin_group2;
    logic [7:0] wake_ctrl;
    logic [7:0] irq_mask;
    logic prev_req_n;
    logic irq;
  } wese_top_state_t;

  wese_top_state_t s;
  wese_top_state_t next_s;

  wese_flag_if #(.W(8)) status5_if ();
  wese_flag_if #(.W(8)) irq_if ();

  logic [7:0] misc_status;
  logic [7:0] grp2_status;
  logic gate_req_n;
  logic wr_fire;
  logic rd_fire;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_mapped;
  logic rd_mapped;
  logic [7:0] rd_value;

  // group-5 status bits, reset only by the standby-power reset
  wese_sticky #(
    .W(8),
    .RESET_VALUE(WAKE_STATUS_RESET)
  ) u_status5 (
    .aclk(aclk),
    .aresetn(aresetn),
    .f(status5_if.bank)
  );

  // interrupt status bits, cleared by reading them
  wese_sticky #(
    .W(8),
    .RESET_VALUE(IRQ_STATUS_RESET)
  ) u_irq_status (
    .aclk(aclk),
    .aresetn(aresetn),
    .f(irq_if.bank)
  );

  // the misc sources placed at their enable bit positions
  always_comb
  begin
    misc_status = 8'h00;
    misc_status[CONSUMER_INFRARED_POS] = consumer_infrared_wake;
    misc_status[RING_TWO_POS] = ring_indicator_two;
    misc_status[RING_ONE_POS] = ring_indicator_one;
    misc_status[KEYBOARD_POS] = keyboard_wake;
    misc_status[MOUSE_POS] = mouse_wake;
    misc_status[SPECIFIC_KEY_POS] = specific_key_wake;
    misc_status[FAN_ONE_POS] = fan_speed_input_one;
    misc_status[FAN_TWO_POS] = fan_speed_input_two;
  end

  // group-2 pin 3 has no wake role; the grouped interrupt takes its slot
  always_comb
  begin
    grp2_status = pin_group2_wake_status;
    grp2_status[GROUPED_INT_POS] = grouped_interrupt_wake;
  end

  // enable bits line up one to one with the assembled status vector
  // the gate flop costs one cycle of latency but keeps the wake line glitch free
  wese_gate #(
    .N(24)
  ) u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .status({grp2_status, pin_group1_wake_status, misc_status}),
    .enable({s.wake_enable_pin_group2, s.wake_enable_pin_group1,
             s.wake_enable_misc_sources}),
    .global_enable(s.wake_ctrl[GLOBAL_ENABLE_POS]),
    .wake_request_n(gate_req_n)
  );

  // address decode; bits above the index are checked, the two bits below the word are ignored
  always_comb
  begin
    wr_idx = s.waddr[7:2];
    rd_idx = s.raddr[7:2];
    wr_mapped = 1'b0;
    rd_mapped = 1'b0;
    if (ADDR_W > 8 && (s.waddr >> 8) != '0)
      wr_mapped = 1'b0;
    else if (wr_idx >= IDX_STATUS_GRP5 && wr_idx <= IDX_EN_GRP2)
      wr_mapped = 1'b1;
    else if (wr_idx >= IDX_WAKE_CTRL && wr_idx <= IDX_IRQ_MASK)
      wr_mapped = 1'b1;
    if (ADDR_W > 8 && (s.raddr >> 8) != '0)
      rd_mapped = 1'b0;
    else if (rd_idx >= IDX_STATUS_GRP5 && rd_idx <= IDX_EN_GRP2)
      rd_mapped = 1'b1;
    else if (rd_idx >= IDX_WAKE_CTRL && rd_idx <= IDX_IRQ_MASK)
      rd_mapped = 1'b1;
  end

  // read value of the addressed register
  always_comb
  begin
    rd_value = 8'h00;
    if (!rd_mapped)
      rd_value = 8'h00;
    else if (rd_idx == IDX_STATUS_GRP5)
      rd_value = status5_if.flags;
    else if (rd_idx == IDX_RESERVED_ZERO)
      rd_value = 8'h00;
    else if (rd_idx == IDX_EN_MISC)
      rd_value = s.wake_enable_misc_sources;
    else if (rd_idx == IDX_EN_GRP1)
      rd_value = s.wake_enable_pin_group1;
    else if (rd_idx == IDX_EN_GRP2)
      rd_value = s.wake_enable_pin_group2;
    else if (rd_idx == IDX_WAKE_CTRL)
      rd_value = s.wake_ctrl;
    else if (rd_idx == IDX_IRQ_STATUS)
      rd_value = irq_if.flags;
    else if (rd_idx == IDX_IRQ_MASK)
      rd_value = s.irq_mask;
  end

  // the write lands once address and data have both been taken
  // bvalid in the guard stops a held pair from landing twice before the answer
  assign wr_fire = s.have_aw && s.have_w && !s.bvalid;
  assign rd_fire = s.rd_pend;

  // group-5 status: pins set, software clears by writing ones
  always_comb
  begin
    status5_if.set = pin_group5_wake;
    status5_if.w1c = 8'h00;
    status5_if.rd_clr = 1'b0;
    if (wr_fire && s.wlane0 && wr_mapped && wr_idx == IDX_STATUS_GRP5)
      status5_if.w1c = s.wdata;
  end

  // interrupt events: a new group-5 bit, or the wake request going active
  // bit 0 only sees a fresh group-5 bit, so a held pin gives a single event
  always_comb
  begin
    irq_if.set = 8'h00;
    irq_if.set[IRQ_GRP5_EVENT_POS] = |(pin_group5_wake & ~status5_if.flags);
    irq_if.set[IRQ_WAKE_ASSERT_POS] = s.prev_req_n && !gate_req_n;
    irq_if.w1c = 8'h00;
    irq_if.rd_clr = rd_fire && rd_mapped && rd_idx == IDX_IRQ_STATUS;
  end

  // bus handshakes, register writes and the interrupt level
  always_comb
  begin
    next_s = s;
    // write address and data are taken independently, in any order
    if (s_axi_awvalid && s.awready)
    begin
      next_s.awready = 1'b0;
      next_s.have_aw = 1'b1;
      next_s.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.wready = 1'b0;
      next_s.have_w = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wlane0 = s_axi_wstrb[0];
    end
    // only byte lane 0 carries data; other lanes are accepted and dropped
    if (wr_fire)
    begin
      next_s.have_aw = 1'b0;
      next_s.have_w = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
      if (s.wlane0 && wr_mapped)
      begin
        if (wr_idx == IDX_EN_MISC)
          next_s.wake_enable_misc_sources = s.wdata;
        else if (wr_idx == IDX_EN_GRP1)
          next_s.wake_enable_pin_group1 = s.wdata;
        else if (wr_idx == IDX_EN_GRP2)
          next_s.wake_enable_pin_group2 = s.wdata;
        else if (wr_idx == IDX_WAKE_CTRL)
          next_s.wake_ctrl = s.wdata & 8'h01;
        else if (wr_idx == IDX_IRQ_MASK)
          next_s.irq_mask = s.wdata & 8'h03;
      end
    end
    // channels reopen only once the response has gone
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    // read: take the address, look up one cycle later, then answer
    if (s_axi_arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rd_pend = 1'b1;
      next_s.raddr = s_axi_araddr;
    end
    if (rd_fire)
    begin
      next_s.rd_pend = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_value;
      next_s.rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    next_s.prev_req_n = gate_req_n;
    // level interrupt, one cycle behind the status bits
    next_s.irq = |(irq_if.flags & s.irq_mask);
  end

  // aresetn is the standby-power reset; main resets do not reach here
  // main and soft resets have no port, so all software-visible state survives them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.have_aw <= 1'b0;
      s.have_w <= 1'b0;
      s.waddr <= '0;
      s.wdata <= 8'h00;
      s.wlane0 <= 1'b0;
      s.bvalid <= 1'b0;
      s.bresp <= RESP_OKAY;
      s.arready <= 1'b1;
      s.rd_pend <= 1'b0;
      s.raddr <= '0;
      s.rvalid <= 1'b0;
      s.rresp <= RESP_OKAY;
      s.rdata <= 8'h00;
      s.wake_enable_misc_sources <= WAKE_ENABLE_RESET;
      s.wake_enable_pin_group1 <= WAKE_ENABLE_RESET;
      s.wake_enable_pin_group2 <= WAKE_ENABLE_RESET;
      s.wake_ctrl <= WAKE_CTRL_RESET;
      s.irq_mask <= IRQ_MASK_RESET;
      s.prev_req_n <= 1'b1;
      s.irq <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // every bus output comes straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h000000, s.rdata};
  assign wake_request_n = gate_req_n;
  assign irq = s.irq;
endmodule

// ===== bench/wese_chk.sv
// port assertions for the wake event status and enable block
module wese_chk
  import wese_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic consumer_infrared_wake,
  input wire logic ring_indicator_one,
  input wire logic ring_indicator_two,
  input wire logic keyboard_wake,
  input wire logic mouse_wake,
  input wire logic specific_key_wake,
  input wire logic fan_speed_input_one,
  input wire logic fan_speed_input_two,
  input wire logic [7:0] pin_group1_wake_status,
  input wire logic [7:0] pin_group2_wake_status,
  input wire logic grouped_interrupt_wake,
  input wire logic wake_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic any_src;
  logic [5:0] rd_idx;

  // any level that could pull the wake line; group-2 slot 3 belongs to the grouped interrupt
  assign any_src = consumer_infrared_wake | ring_indicator_one | ring_indicator_two |
    keyboard_wake | mouse_wake | specific_key_wake | fan_speed_input_one |
    fan_speed_input_two | (|pin_group1_wake_status) | (|(pin_group2_wake_status & 8'hf7)) |
    grouped_interrupt_wake;

  // keep the index of the read in flight so its answer can be judged
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      rd_idx <= s_axi_araddr[7:2];
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_wake_idle_reset: assert property ($rose(aresetn) |-> wake_request_n && !s_axi_bvalid)
    else $error("wake line or response busy after reset");
  a_wake_needs_src: assert property (!wake_request_n |-> $past(any_src))
    else $error("wake request without any source level");
  a_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (rd_taken |-> ##[1:3] s_axi_rvalid)
    else $error("read data missing");
  a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_w_reopen: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  a_ar_reopen: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready)
    else $error("read channel not reopened");
  a_rsvd_zero: assert property (s_axi_rvalid && rd_idx == IDX_RESERVED_ZERO |->
    s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY) else $error("reserved word not zero");
endmodule

// ===== bench/wese_host_pm.sv
// host power-management model: counts requests on the shared wake line
module wese_host_pm
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wake_request_n,
  output logic [7:0] wake_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_n;

  // a chipset latches each new low level; a held low is one request, not many
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wake_count <= 8'h00;
      last_n <= 1'b1;
    end
    else
    begin
      last_n <= wake_request_n;
      if (last_n && !wake_request_n)
        wake_count <= wake_count + 8'h01;
    end
  end
endmodule

// ===== bench/wake_event_status_enable_tb.sv
// self-checking bench for the wake event status and enable block
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module wake_event_status_enable_tb
  import wese_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, noise, g, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pin_group5_wake, wake_count, v, m;
  logic [7:0] pin_group1_wake_status, pin_group2_wake_status;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic consumer_infrared_wake, ring_indicator_one, ring_indicator_two, keyboard_wake;
  logic mouse_wake, specific_key_wake, fan_speed_input_one, fan_speed_input_two;
  logic grouped_interrupt_wake, wake_request_n;
  logic [23:0] src, e, s;
  int bad_count, cmp_count, cycles;

  wese_top u_dut (.*);
  wese_host_pm u_host (.*);

  // source slots: misc enable order, then group 1, then group 2 with slot 3 the grouped interrupt
  assign {fan_speed_input_two, fan_speed_input_one, specific_key_wake, mouse_wake, keyboard_wake,
    ring_indicator_one, ring_indicator_two, consumer_infrared_wake} = src[7:0];
  assign pin_group1_wake_status = src[15:8];
  assign pin_group2_wake_status = {src[23:20], noise, src[18:16]};
  assign grouped_interrupt_wake = src[19];

  // free-running 125 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // hang guard: no run needs this many cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  function automatic logic exp_wake(input logic [23:0] sv, input logic [23:0] ev, input logic gv);
    return !(gv && (|(sv & ev)));
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // write one register word; address and data are released each at its own acceptance
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w))
    begin
      @(posedge aclk);
      a = a | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
    end
    do
      @(posedge aclk);
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // read one register word and compare data and response
  task automatic rchk(input logic [5:0] idx, input logic [7:0] ex, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge aclk);
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK("rdata", {24'h0, ex}, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  task automatic set_en(input logic [23:0] ev, input logic gv);
    wr(IDX_EN_MISC, ev[7:0]);
    wr(IDX_EN_GRP1, ev[15:8]);
    wr(IDX_EN_GRP2, ev[23:16]);
    wr(IDX_WAKE_CTRL, {7'h0, gv});
  endtask

  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask

  // the status and enable words at indices 8 to 12 read zero, index 13 is unmapped
  task automatic check_cleared();
    for (int i = 8; i < 14; i++)
      rchk(6'(i), 8'h00, (i == 13) ? RESP_SLVERR : RESP_OKAY);
  endtask

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, noise} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pin_group5_wake, src} = '0;
    s_axi_wstrb = 4'hf;
    v = 8'($urandom(32'h09a3));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    check_cleared();
    wr(IDX_RESERVED_ZERO, 8'hff);
    `CHK("bresp", RESP_OKAY, r)
    rchk(IDX_RESERVED_ZERO, 8'h00, RESP_OKAY);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'hff : 8'($urandom);
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      @(posedge aclk);
      pin_group5_wake <= v;
      @(posedge aclk);
      pin_group5_wake <= 8'h00;
      rchk(IDX_STATUS_GRP5, v, RESP_OKAY);
      wr(IDX_STATUS_GRP5, m);
      rchk(IDX_STATUS_GRP5, v & ~m, RESP_OKAY);
      wr(IDX_STATUS_GRP5, 8'hff);
      `CHK("irq", 1'b0, irq)
    end
    $display("test status_clear done");
    for (int k = 0; k < 24; k++)
    begin
      e = 24'h1 << k;
      set_en(e, 1'b1);
      src <= e;
      settle();
      `CHK("wake_request_n", 1'b0, wake_request_n)
      set_en(~e, 1'b1);
      settle();
      `CHK("wake_request_n", 1'b1, wake_request_n)
    end
    `CHK("wake_count", 8'h18, wake_count)
    $display("test source_map done");
    for (int i = 0; i < 40; i++)
    begin
      e = 24'($urandom);
      s = i[0] ? 24'($urandom) : 24'h1 << ($urandom % 24);
      g = 1'($urandom);
      set_en(e, g);
      src <= s;
      noise <= 1'($urandom);
      settle();
      `CHK("wake_request_n", exp_wake(s, e, g), wake_request_n)
    end
    $display("test random_gate done");
    set_en(24'h0, 1'b0);
    wr(IDX_IRQ_MASK, 8'h01);
    rchk(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
    @(posedge aclk);
    pin_group5_wake <= 8'h04;
    @(posedge aclk);
    pin_group5_wake <= 8'h00;
    settle();
    `CHK("irq", 1'b1, irq)
    rchk(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
    settle();
    `CHK("irq", 1'b0, irq)
    $display("test interrupt done");
    set_en(24'ha5a5a5, 1'b1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    check_cleared();
    $display("test standby_reset done");
    finish_test();
  end
endmodule

bind wese_top wese_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
